// ===== hw/cdc_sync.sv
`timescale 1ns/1ps

module cdc_sync
  import line_ovh_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // two flops; first one is read only by the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// ===== hw/line_ovh_pkg.sv
package line_ovh_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;  // mode, clocking, polarity
  localparam logic [3:0]  ADDR_BPV    = 4'h4;  // violation count
  localparam logic [3:0]  ADDR_OVH    = 4'h8;  // overhead port status
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_3f3f;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_LSB  = 0;   // three bits of framing mode
  localparam int CTRL_MODE_MSB  = 2;
  localparam int CTRL_UNIPOL    = 3;   // unipolar line mode
  localparam int CTRL_CLK_SEL   = 4;   // use recovered clock
  localparam int CTRL_CLK_INV   = 5;   // sample on falling edge
  localparam int CTRL_INV_NEG   = 8;
  localparam int CTRL_INV_POS   = 9;
  localparam int CTRL_INV_OHD   = 10;
  localparam int CTRL_INV_OHEN  = 11;
  localparam int CTRL_INV_OHCLK = 12;
  localparam int CTRL_INV_SOF   = 13;
  localparam int OVH_IDX_LSB    = 8;   // index field in overhead status

  // ---------------------------------------------------------------
  // framing modes; bit 2 marks the overhead-mask variants
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_CLEAR     = 3'b000,
    MODE_T3        = 3'b001,
    MODE_G751      = 3'b010,
    MODE_G832      = 3'b011,
    MODE_CLEAR_OHM = 3'b100,
    MODE_T3_OHM    = 3'b101,
    MODE_G751_OHM  = 3'b110,
    MODE_G832_OHM  = 3'b111
  } framing_mode_t;
  localparam int MODE_OHM_BIT = 2;

  // ---------------------------------------------------------------
  // widths and overhead sequence lengths
  // ---------------------------------------------------------------
  localparam int         BPV_W       = 16;
  localparam int         IDX_W       = 6;
  localparam logic [5:0] OVH_LEN_T3  = 6'h38;  // bits per overhead sequence
  localparam logic [5:0] OVH_LEN_751 = 6'h0c;
  localparam logic [5:0] OVH_LEN_832 = 6'h38;
  localparam logic [5:0] IDX_ZERO    = 6'h00;
  localparam logic [5:0] IDX_ONE     = 6'h01;

endpackage

// ===== hw/line_rx_ovh.sv
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps

module line_rx_ovh
  import line_ovh_pkg::*;
#(
  parameter logic [5:0] LEN_T3  = OVH_LEN_T3,
  parameter logic [5:0] LEN_751 = OVH_LEN_751,
  parameter logic [5:0] LEN_832 = OVH_LEN_832
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // register port
  input  wire logic [3:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rdata_o,
  // receive line pins
  input  wire logic              rx_line_clock_in_i,
  input  wire logic              rx_recovered_clock_out_i,
  input  wire logic              rx_unipolar_data_in_i,
  input  wire logic              rx_neg_pulse_in_i,
  output logic                   rx_neg_pulse_o,
  output logic                   rx_payload_bit_o,
  output logic                   rx_payload_valid_o,
  output logic      [BPV_W-1:0]  bpv_count_o,
  // transmit overhead port
  input  wire logic              tx_overhead_clock_i,
  input  wire logic              tx_overhead_frame_start_i,
  input  wire logic              tx_overhead_data_in_i,
  input  wire logic              tx_overhead_enable_in_i,
  input  wire logic              gen_ovh_bit_i,
  output logic                   tx_ovh_strobe_o,
  output logic                   tx_ovh_bit_o,
  output logic                   tx_ovh_overwrite_o,
  output logic      [IDX_W-1:0]  tx_ovh_index_o
);

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  wire         hit_ctrl = (addr_i == ADDR_CTRL);
  wire         hit_bpv  = (addr_i == ADDR_BPV);
  wire         hit_ovh  = (addr_i == ADDR_OVH);
  wire [31:0]  bpv_word = {{(32-BPV_W){1'b0}}, bpv_count_o};
  wire [31:0]  ovh_word = {18'h0_0000, tx_ovh_index_o, 6'h00, tx_ovh_overwrite_o,
                           tx_ovh_bit_o};
  wire [31:0]  next_rdata = !rd_i    ? READ_ZERO :
                            hit_ctrl ? ctrl      :
                            hit_bpv  ? bpv_word  :
                            hit_ovh  ? ovh_word  : READ_ZERO;

  // control write, read data one cycle later
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl    <= CTRL_RESET;
      rdata_o <= READ_ZERO;
    end else begin
      if (wr_i && hit_ctrl) begin
        ctrl <= wdata_i & CTRL_MASK;
      end
      rdata_o <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  framing_mode_t mode;
  assign mode = framing_mode_t'(ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB]);
  wire framed   = (mode == MODE_T3) || (mode == MODE_G751) || (mode == MODE_G832);
  wire [5:0] seq_len = (mode == MODE_T3)   ? LEN_T3  :
                       (mode == MODE_G751) ? LEN_751 : LEN_832;

  // ---------------------------------------------------------------
  // receive reference clock
  // ---------------------------------------------------------------
  // select and invert; select and invert are static, set while idle
  wire rx_sel_clk = ctrl[CTRL_CLK_SEL] ? rx_recovered_clock_out_i
                                       : rx_line_clock_in_i;
  wire rx_ref_clk = rx_sel_clk ^ ctrl[CTRL_CLK_INV];

  logic link_rst_n;
  logic [3:0] link_cfg;

  // reset release into the line domain
  cdc_sync #(.WIDTH(1)) u_link_rst (
    .clk_i   (rx_ref_clk),
    .rst_n_i (rst_n_i),
    .d_i     (1'b1),
    .q_o     (link_rst_n)
  );

  // configuration bits the line logic needs
  cdc_sync #(.WIDTH(4)) u_link_cfg (
    .clk_i   (rx_ref_clk),
    .rst_n_i (rst_n_i),
    .d_i     ({ctrl[CTRL_INV_POS], ctrl[CTRL_INV_NEG], ctrl[CTRL_UNIPOL],
               ctrl[CTRL_MODE_LSB + MODE_OHM_BIT]}),
    .q_o     (link_cfg)
  );

  wire l_ohm     = link_cfg[0];
  wire l_unipol  = link_cfg[1];
  wire l_inv_neg = link_cfg[2];
  wire l_inv_pos = link_cfg[3];

  // ---------------------------------------------------------------
  // receive line sampling
  // ---------------------------------------------------------------
  logic s1_neg, s1_pos, s2_neg, s2_pos;
  logic [BPV_W-1:0] bpv_bin, bpv_gray;
  wire  neg_in = rx_neg_pulse_in_i ^ l_inv_neg;
  wire  pos_in = rx_unipolar_data_in_i ^ l_inv_pos;
  wire  rx_code_violation_in = s2_neg;   // same pin, unipolar meaning
  wire  rx_overhead_mask_in  = s2_neg;   // same pin, mask-mode meaning
  wire  count_bpv = l_unipol && !l_ohm && rx_code_violation_in;
  wire  [BPV_W-1:0] next_bpv_bin  = bpv_bin + {{(BPV_W-1){1'b0}}, count_bpv};
  wire  [BPV_W-1:0] next_bpv_gray = next_bpv_bin ^ (next_bpv_bin >> 1);

  // sample stage and retime stage
  always_ff @(posedge rx_ref_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      s1_neg <= 1'b0;
      s1_pos <= 1'b0;
      s2_neg <= 1'b0;
      s2_pos <= 1'b0;
    end else begin
      s1_neg <= neg_in;
      s1_pos <= pos_in;
      s2_neg <= s1_neg;
      s2_pos <= s1_pos;
    end
  end

  // line decode: pulse, payload, violation count
  always_ff @(posedge rx_ref_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_neg_pulse_o     <= 1'b0;
      rx_payload_bit_o   <= 1'b0;
      rx_payload_valid_o <= 1'b0;
      bpv_bin            <= '0;
      bpv_gray           <= '0;
    end else begin
      rx_neg_pulse_o     <= s2_neg && !l_unipol && !l_ohm;
      rx_payload_bit_o   <= s2_pos;
      rx_payload_valid_o <= !(l_ohm && rx_overhead_mask_in);
      bpv_bin            <= next_bpv_bin;
      bpv_gray           <= next_bpv_gray;
    end
  end

  // ---------------------------------------------------------------
  // violation count back to the register side
  // ---------------------------------------------------------------
  logic [BPV_W-1:0] bpv_gray_s;

  cdc_sync #(.WIDTH(BPV_W)) u_bpv_sync (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (bpv_gray),
    .q_o     (bpv_gray_s)
  );

  function automatic logic [BPV_W-1:0] gray_to_bin(input logic [BPV_W-1:0] g);
    logic [BPV_W-1:0] b;
    b[BPV_W-1] = g[BPV_W-1];
    for (int i = BPV_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // registered binary count
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bpv_count_o <= '0;
    end else begin
      bpv_count_o <= gray_to_bin(bpv_gray_s);
    end
  end

  // ---------------------------------------------------------------
  // transmit overhead port
  // ---------------------------------------------------------------
  logic [3:0] ovh_s;
  logic       ovh_clk_d;
  logic [5:0] ovh_idx;

  cdc_sync #(.WIDTH(4)) u_ovh_sync (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({tx_overhead_frame_start_i, tx_overhead_enable_in_i,
               tx_overhead_data_in_i, tx_overhead_clock_i}),
    .q_o     (ovh_s)
  );

  // polarity applied after the second flop
  wire ovh_clk  = ovh_s[0] ^ ctrl[CTRL_INV_OHCLK];
  wire ovh_data = ovh_s[1] ^ ctrl[CTRL_INV_OHD];
  wire ovh_en   = ovh_s[2] ^ ctrl[CTRL_INV_OHEN];
  wire ovh_sof  = ovh_s[3] ^ ctrl[CTRL_INV_SOF];
  wire ovh_fall = ovh_clk_d && !ovh_clk;
  wire ovh_last = (ovh_idx == 6'(seq_len - IDX_ONE));
  wire ovh_take = framed && ovh_en;
  wire [5:0] next_ovh_idx = (ovh_sof || ovh_last) ? IDX_ZERO
                                                  : 6'(ovh_idx + IDX_ONE);

  // position in the overhead sequence
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovh_clk_d <= 1'b0;
      ovh_idx   <= IDX_ZERO;
    end else begin
      ovh_clk_d <= ovh_clk;
      if (ovh_fall) begin
        ovh_idx <= next_ovh_idx;
      end
    end
  end

  // merged overhead bit, one per overhead clock fall
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_ovh_strobe_o    <= 1'b0;
      tx_ovh_bit_o       <= 1'b0;
      tx_ovh_overwrite_o <= 1'b0;
      tx_ovh_index_o     <= IDX_ZERO;
    end else begin
      tx_ovh_strobe_o <= ovh_fall;
      if (ovh_fall) begin
        tx_ovh_bit_o       <= ovh_take ? ovh_data : gen_ovh_bit_i;
        tx_ovh_overwrite_o <= ovh_take;
        tx_ovh_index_o     <= ovh_sof ? IDX_ZERO : next_ovh_idx;
      end
    end
  end

  // marker seen at the previous overhead clock fall, taken or not, for the position check
  logic sof_prev;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sof_prev <= 1'b0;
    end else if (ovh_fall) begin
      sof_prev <= ovh_sof;
    end
  end

  // ---------------------------------------------------------------
  // checks, line domain
  // ---------------------------------------------------------------
  chk_neg_pulse_map: assert property (@(posedge rx_ref_clk) disable iff (!link_rst_n)
    (s2_neg && !l_unipol && !l_ohm) |=> rx_neg_pulse_o)
    else $error("negative pulse not reported");

  chk_sample_path: assert property (@(posedge rx_ref_clk) disable iff (!link_rst_n)
    neg_in |=> ##1 s2_neg)
    else $error("sampled input did not reach retime stage");

  chk_bpv_count: assert property (@(posedge rx_ref_clk) disable iff (!link_rst_n)
    count_bpv |=> (bpv_bin == $past(bpv_bin) + 1'b1))
    else $error("violation count did not advance");

  chk_mask_drop: assert property (@(posedge rx_ref_clk) disable iff (!link_rst_n)
    (l_ohm && s2_neg) |=> !rx_payload_valid_o)
    else $error("masked bit taken as payload");

  chk_neg_invert: assert property (@(posedge rx_ref_clk) disable iff (!link_rst_n)
    (l_inv_neg && rx_neg_pulse_in_i && $stable(l_inv_neg)) |=> !s1_neg)
    else $error("negative input inversion not applied");

  // ---------------------------------------------------------------
  // checks, register domain
  // ---------------------------------------------------------------
  chk_clock_select: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ctrl[CTRL_CLK_SEL] |-> (rx_sel_clk == rx_recovered_clock_out_i))
    else $error("recovered clock not selected");

  chk_ovh_replace: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ovh_fall && ovh_take) |=> (tx_ovh_overwrite_o && tx_ovh_bit_o == $past(ovh_data)))
    else $error("enabled overhead bit not inserted");

  chk_t3_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ovh_fall && mode == MODE_T3 && !ovh_sof && ovh_idx == 6'(LEN_T3 - IDX_ONE))
    |=> (ovh_idx == IDX_ZERO))
    else $error("t3 overhead sequence length wrong");

  chk_751_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ovh_fall && mode == MODE_G751 && !ovh_sof && ovh_idx == 6'(LEN_751 - IDX_ONE))
    |=> (ovh_idx == IDX_ZERO))
    else $error("g751 overhead sequence length wrong");

  chk_832_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ovh_fall && mode == MODE_G832 && !ovh_sof && ovh_idx == 6'(LEN_832 - IDX_ONE))
    |=> (ovh_idx == IDX_ZERO))
    else $error("g832 overhead sequence length wrong");

  chk_fall_strobe: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(ovh_clk) |-> ##1 tx_ovh_strobe_o ##1 !tx_ovh_strobe_o)
    else $error("overhead not sampled on clock fall");

  chk_enable_select: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ovh_fall && !ovh_en) |=> !tx_ovh_overwrite_o)
    else $error("bit overwritten without enable");

  chk_sof_align: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ovh_fall && ovh_sof) |=> (tx_ovh_index_o == IDX_ZERO) && (ovh_idx == IDX_ZERO))
    else $error("sequence not aligned to start marker");

  chk_after_sof: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ovh_fall && !ovh_sof && sof_prev) |=> (tx_ovh_index_o == IDX_ONE))
    else $error("bit after start marker has wrong position");

  chk_unframed_pass: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ovh_fall && !framed) |=> (!tx_ovh_overwrite_o && tx_ovh_bit_o == $past(gen_ovh_bit_i)))
    else $error("overhead inserted outside framed mode");

  cov_bpv_event: cover property (@(posedge rx_ref_clk) disable iff (!link_rst_n)
    count_bpv);
  cov_mask_drop: cover property (@(posedge rx_ref_clk) disable iff (!link_rst_n)
    l_ohm && s2_neg);
  cov_ovh_insert: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ovh_fall && ovh_take && ovh_sof);
  cov_ovh_wrap: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ovh_fall && ovh_last && !ovh_sof);
  cov_after_sof: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ovh_fall && !ovh_sof && sof_prev);

endmodule

// ===== test/ext_line_ovh_model.sv
`timescale 1ns/1ps

// far side of the port: line interface unit on the receive pins and
// external overhead insertion logic on the transmit overhead port
module ext_line_ovh_model (
  input  wire logic       pin_clk_i,
  input  wire logic       pin_inv_i,
  input  wire logic [3:0] ovh_inv_i,
  output logic            rx_data_o,
  output logic            rx_neg_o,
  output logic            ovh_clk_o,
  output logic            ovh_sof_o,
  output logic            ovh_data_o,
  output logic            ovh_en_o
);
  logic clk_q;
  logic sof_q;
  logic data_q;
  logic en_q;
  wire  chg_clk = pin_clk_i ^ ~pin_inv_i;

  // ---------------------------------------------------------------
  // line pins
  // ---------------------------------------------------------------
  initial begin
    rx_data_o = 1'b0;
    rx_neg_o  = 1'b0;
    clk_q     = 1'b1;
    sof_q     = 1'b0;
    data_q    = 1'b0;
    en_q      = 1'b0;
  end

  // pins move on the edge opposite the sampling one; data toggles every bit
  always @(posedge chg_clk) rx_data_o <= ~rx_data_o;

  // n bits at level lvl, then hold the opposite level
  task automatic neg_burst(input int n, input logic lvl);
    repeat (n) begin
      @(posedge chg_clk);
      rx_neg_o <= lvl;
    end
    @(posedge chg_clk);
    rx_neg_o <= ~lvl;
  endtask

  // ---------------------------------------------------------------
  // overhead port
  // ---------------------------------------------------------------
  // pins carry the polarity the device is told to expect
  assign ovh_clk_o  = clk_q ^ ovh_inv_i[2];
  assign ovh_sof_o  = sof_q ^ ovh_inv_i[3];
  assign ovh_data_o = data_q ^ ovh_inv_i[0];
  assign ovh_en_o   = en_q ^ ovh_inv_i[1];

  // one frame of n bits, updated after each clock rise; clock idles high
  task automatic ovh_frame(input int n, input logic [15:0] d, input logic [15:0] e);
    #7;  // keep pin changes off the reference clock edges
    for (int i = 0; i < n; i++) begin
      sof_q  = (i == 0);
      data_q = d[i % 16];
      en_q   = e[i % 16];
      #500 clk_q = 1'b0;
      #500 clk_q = 1'b1;
    end
    // released data and enable show the inverse of the last value; the start marker goes low
    sof_q  = 1'b0;
    data_q = ~data_q;
    en_q   = ~en_q;
  endtask
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import line_ovh_pkg::*;

  localparam logic [31:0] UPOL = 32'h0000_0001 << CTRL_UNIPOL;
  localparam logic [31:0] CSEL = 32'h0000_0001 << CTRL_CLK_SEL;
  localparam logic [31:0] CINV = 32'h0000_0001 << CTRL_CLK_INV;
  localparam logic [31:0] INEG = 32'h0000_0001 << CTRL_INV_NEG;
  localparam logic [31:0] IOVH = 32'h0000_3c00;

  logic             ref_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [3:0]       addr = 4'h0;
  logic [31:0]      wdata = 32'h0000_0000;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic [31:0]      rdata;
  logic             lclk = 1'b0;
  logic             rclk = 1'b0;
  logic             lclk_run = 1'b1;
  logic             rclk_run = 1'b1;
  logic             sel = 1'b0;
  logic             inv = 1'b0;
  logic [3:0]       ovh_inv = 4'h0;
  logic             gen = 1'b0;
  logic             rx_data;
  logic             rx_neg;
  logic             rx_neg_pulse_o;
  logic             rx_payload_bit_o;
  logic             rx_payload_valid_o;
  logic [BPV_W-1:0] bpv_count_o;
  logic             ovh_clk;
  logic             ovh_sof;
  logic             ovh_data;
  logic             ovh_en;
  logic             tx_ovh_strobe_o;
  logic             tx_ovh_bit_o;
  logic             tx_ovh_overwrite_o;
  logic [IDX_W-1:0] tx_ovh_index_o;
  logic [7:0]       ovh_q[$];
  int               err_total = 0;
  int               checks = 0;
  int               cycles = 0;
  int               neg_seen = 0;
  int               drop_seen = 0;
  int               same_seen = 0;
  logic             pay_prev = 1'b0;
  wire              pin_clk = sel ? rclk : lclk;
  wire              line_ref = pin_clk ^ inv;

  // ---------------------------------------------------------------
  // clocks: line clocks at 32 ns, phase unrelated to the reference
  // ---------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;
  initial begin
    #5;
    forever #16 lclk = lclk_run ? ~lclk : 1'b0;
  end
  initial begin
    #11;
    forever #16 rclk = rclk_run ? ~rclk : 1'b0;
  end

  line_rx_ovh i_line_rx_ovh (
    .ref_clk_i                (ref_clk),
    .rst_n_i                  (rst_n),
    .addr_i                   (addr),
    .wdata_i                  (wdata),
    .wr_i                     (wr),
    .rd_i                     (rd),
    .rdata_o                  (rdata),
    .rx_line_clock_in_i       (lclk),
    .rx_recovered_clock_out_i (rclk),
    .rx_unipolar_data_in_i    (rx_data),
    .rx_neg_pulse_in_i        (rx_neg),
    .rx_neg_pulse_o           (rx_neg_pulse_o),
    .rx_payload_bit_o         (rx_payload_bit_o),
    .rx_payload_valid_o       (rx_payload_valid_o),
    .bpv_count_o              (bpv_count_o),
    .tx_overhead_clock_i      (ovh_clk),
    .tx_overhead_frame_start_i(ovh_sof),
    .tx_overhead_data_in_i    (ovh_data),
    .tx_overhead_enable_in_i  (ovh_en),
    .gen_ovh_bit_i            (gen),
    .tx_ovh_strobe_o          (tx_ovh_strobe_o),
    .tx_ovh_bit_o             (tx_ovh_bit_o),
    .tx_ovh_overwrite_o       (tx_ovh_overwrite_o),
    .tx_ovh_index_o           (tx_ovh_index_o)
  );

  ext_line_ovh_model i_ext_line_ovh_model (
    .pin_clk_i (pin_clk),
    .pin_inv_i (inv),
    .ovh_inv_i (ovh_inv),
    .rx_data_o (rx_data),
    .rx_neg_o  (rx_neg),
    .ovh_clk_o (ovh_clk),
    .ovh_sof_o (ovh_sof),
    .ovh_data_o(ovh_data),
    .ovh_en_o  (ovh_en)
  );

  // ---------------------------------------------------------------
  // monitors and hang guard
  // ---------------------------------------------------------------
  always @(posedge line_ref) begin
    if (rx_neg_pulse_o === 1'b1) neg_seen++;
    if (rx_payload_valid_o === 1'b0) drop_seen++;
    if (rx_payload_bit_o === pay_prev) same_seen++;
    pay_prev = rx_payload_bit_o;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (tx_ovh_strobe_o === 1'b1) ovh_q.push_back({tx_ovh_index_o, tx_ovh_overwrite_o, tx_ovh_bit_o});
    if (cycles == 6000) begin
      err_total++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk("register read", exp, d);
  endtask

  // line clocks stand still while clock choice and mode change
  task automatic cfg(input logic [31:0] c);
    lclk_run = 1'b0;
    rclk_run = 1'b0;
    repeat (2) @(posedge ref_clk);
    wr_reg(ADDR_CTRL, c);
    sel      = c[CTRL_CLK_SEL];
    inv      = c[CTRL_CLK_INV];
    lclk_run = !sel;
    rclk_run = sel;
    repeat (8) @(posedge ref_clk);
  endtask

  // burst on the negative pin, then compare count, pulses, dropped bits
  task automatic line_case(input int n, input logic lvl, input int dbpv, input int dneg,
                           input int ddrop);
    logic [31:0] b0;
    logic [31:0] b1;
    rd_reg(ADDR_BPV, b0);
    neg_seen  = 0;
    drop_seen = 0;
    same_seen = 0;
    i_ext_line_ovh_model.neg_burst(n, lvl);
    repeat (12) @(posedge ref_clk);
    rd_reg(ADDR_BPV, b1);
    chk("violation count", b0 + dbpv, b1);
    chk("negative pulses", dneg, neg_seen);
    chk("dropped bits", ddrop, drop_seen);
    chk("payload toggles", 0, same_seen);
    chk("count port", b1, {16'h0000, bpv_count_o});
  endtask

  // one overhead frame; live says whether the check expects insertion
  task automatic ovh_case(input logic [31:0] c, input int n, input logic [15:0] d,
                          input logic [15:0] e, input logic g, input int len,
                          input logic live);
    logic       ow;
    logic [7:0] exp_v;
    logic [7:0] m;
    logic [31:0] r;
    wr_reg(ADDR_CTRL, c);
    ovh_inv <= c[CTRL_INV_SOF:CTRL_INV_OHD];
    gen     <= g;
    repeat (6) @(posedge ref_clk);
    ovh_q.delete();
    i_ext_line_ovh_model.ovh_frame(n, d, e);
    repeat (10) @(posedge ref_clk);
    chk("overhead strobes", n, ovh_q.size());
    m = live ? 8'hff : 8'h03;
    foreach (ovh_q[i]) begin
      ow    = live & e[i % 16];
      exp_v = {6'(i % len), ow, ow ? d[i % 16] : g};
      chk("overhead bit", {24'h0, exp_v & m}, {24'h0, ovh_q[i] & m});
    end
    // status register shows the last merged bit
    rd_reg(ADDR_OVH, r);
    r = r & {18'h0, m[7:2], 6'h00, 2'h3};
    chk("overhead status", {18'h0, exp_v[7:2] & m[7:2], 6'h00, exp_v[1:0]}, r);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_chk(ADDR_CTRL, CTRL_RESET);
    rd_chk(ADDR_BPV, READ_ZERO);
    rd_chk(4'hc, READ_ZERO);
    wr_reg(ADDR_BPV, 32'hffff_ffff);
    rd_chk(ADDR_BPV, READ_ZERO);
    wr_reg(ADDR_CTRL, 32'hffff_ff07);
    rd_chk(ADDR_CTRL, 32'hffff_ff07 & CTRL_MASK);
    cfg(32'(MODE_T3));
    line_case(4, 1'b1, 0, 4, 0);
    cfg(32'(MODE_CLEAR) | UPOL);
    line_case(5, 1'b1, 5, 0, 0);
    cfg(32'(MODE_CLEAR) | UPOL | CINV);
    line_case(3, 1'b1, 3, 0, 0);
    cfg(32'(MODE_CLEAR) | UPOL | CSEL);
    line_case(6, 1'b1, 6, 0, 0);
    cfg(32'(MODE_T3_OHM));
    line_case(3, 1'b1, 0, 0, 3);
    cfg(32'(MODE_CLEAR_OHM) | UPOL);
    line_case(2, 1'b1, 0, 0, 2);
    cfg(32'(MODE_T3));
    i_ext_line_ovh_model.neg_burst(0, 1'b0);
    cfg(32'(MODE_CLEAR) | UPOL | INEG);
    line_case(3, 1'b0, 3, 0, 0);
    ovh_case(32'(MODE_T3), 8, 16'h0053, 16'h00ca, 1'b1, 56, 1'b1);
    ovh_case(32'(MODE_G751), 14, 16'h2a5c, 16'h3ff0, 1'b0, 12, 1'b1);
    ovh_case(32'(MODE_G832), 58, 16'h00a5, 16'h00ff, 1'b1, 56, 1'b1);
    ovh_case(32'(MODE_T3) | IOVH, 58, 16'h0036, 16'h000f, 1'b0, 56, 1'b1);
    ovh_case(32'(MODE_CLEAR), 4, 16'h0000, 16'h000f, 1'b1, 56, 1'b0);
    ovh_case(32'(MODE_T3_OHM), 4, 16'h0000, 16'h000f, 1'b1, 56, 1'b0);
    summarize();
  end
endmodule
